// ### shared/ratio_pkg.sv
// constants and types shared by the ratio calculator and its control port
package ratio_pkg;

  // ****************************************
  // control port framing
  // ****************************************
  localparam logic [7:0] CHIP_ADDR_VALUE  = 8'h9e;
  localparam logic [2:0] BIT_COUNT_LAST   = 3'h7;

  // ****************************************
  // register map (byte addresses of the control port)
  // ****************************************
  localparam logic [7:0] SCALE_SEL_OFFSET = 8'h05;
  localparam logic [7:0] RATIO_OFFSET     = 8'h06;
  localparam logic [7:0] RATIO_LAST_OFF   = 8'h09;
  localparam logic [7:0] PREDIV_OFFSET    = 8'h16;
  localparam int         SCALE_SEL_LSB    = 0;
  localparam int         PREDIV_LSB       = 0;

  // ****************************************
  // ratio format and reset values
  // ****************************************
  localparam int          RATIO_WIDTH      = 32;
  localparam int          RATIO_INT_BITS   = 12;
  localparam int          RATIO_FRAC_BITS  = 20;
  localparam int          SYNTH_WIDTH      = 34;
  localparam logic [31:0] RATIO_RESET      = 32'h0000_0000;
  localparam logic [2:0]  SCALE_SEL_RESET  = 3'h0;
  localparam logic [1:0]  PREDIV_RESET     = 2'h0;

  // ****************************************
  // predivider codes
  // ****************************************
  localparam logic [1:0] PREDIV_DIV4 = 2'h0;
  localparam logic [1:0] PREDIV_DIV2 = 2'h1;
  localparam logic [1:0] PREDIV_DIV1 = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

  typedef enum logic [1:0] {
    PH_CHIP,
    PH_MAP,
    PH_DATA,
    PH_IGNORE
  } port_phase_type;

endpackage : ratio_pkg

// ### src/serial_write_port.sv
// write-only serial control port that turns frames into register byte writes
`timescale 1ns/1ns
module serial_write_port
  import ratio_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    sys_rst_in,
  input  wire logic    cs_n_in,
  input  wire logic    cclk_in,
  input  wire logic    cdin_in,
  output reg_write_type wr_out
);

  typedef struct packed {
    logic           cclk_prev;
    port_phase_type phase;
    logic [2:0]     bit_cnt;
    logic [6:0]     shift;
    logic [7:0]     addr;
    reg_write_type  wr;
  } port_state_type;

  port_state_type cur_ff;
  port_state_type nxt_state;

  // ****************************************
  // frame decode
  // ****************************************
  always_comb begin
    logic [7:0] byte_val;
    byte_val             = {cur_ff.shift, cdin_in};
    nxt_state            = cur_ff;
    nxt_state.cclk_prev  = cclk_in;
    nxt_state.wr.valid   = 1'b0;
    if (cs_n_in) begin
      nxt_state.phase   = PH_CHIP;
      nxt_state.bit_cnt = 3'h0;
    end else if (cclk_in && !cur_ff.cclk_prev) begin
      nxt_state.shift   = byte_val[6:0];
      nxt_state.bit_cnt = cur_ff.bit_cnt + 3'h1;
      if (cur_ff.bit_cnt == BIT_COUNT_LAST) begin
        case (cur_ff.phase)
          PH_CHIP: begin
            nxt_state.phase = (byte_val == CHIP_ADDR_VALUE) ? PH_MAP : PH_IGNORE;
          end
          PH_MAP: begin
            nxt_state.addr  = byte_val;
            nxt_state.phase = PH_DATA;
          end
          PH_DATA: begin
            nxt_state.wr.valid = 1'b1;
            nxt_state.wr.addr  = cur_ff.addr;
            nxt_state.wr.data  = byte_val;
            nxt_state.addr     = cur_ff.addr + 8'h01;
          end
          default: begin
            nxt_state.phase = PH_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign wr_out = cur_ff.wr;

endmodule : serial_write_port

// ### src/synth_ratio_calculator.sv
// ratio register set and effective ratio calculation for the synthesizer
`timescale 1ns/1ns
// Overview of operation
// - hold 32-bit unsigned user ratio as basis
// - upper twelve integer bits, lower twenty fraction
// - factors below 4096, step near 0.954 ppm
// - compensate predivider so ratio is plain out/in
// - modifier scales calculation only, never register
// - select codes map to 1..8 and 1/2..1/16
// - modifier always used; select resets to one
// - predivider codes 10,01,00 divide by 1,2,4
module synth_ratio_calculator
  import ratio_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    cs_n_in,
  input  wire logic                    cclk_in,
  input  wire logic                    cdin_in,
  output logic [RATIO_WIDTH-1:0]       user_ratio_out,
  output logic [2:0]                   ratio_scale_select_out,
  output logic [1:0]                   ref_predivider_select_out,
  output logic [RATIO_WIDTH-1:0]       effective_ratio_out,
  output logic [SYNTH_WIDTH-1:0]       synth_ratio_out
);

  typedef struct packed {
    logic [RATIO_WIDTH-1:0] user_ratio;
    logic [2:0]             scale_sel;
    logic [1:0]             prediv_sel;
    logic [RATIO_WIDTH-1:0] effective_ratio;
    logic [SYNTH_WIDTH-1:0] synth_ratio;
  } calc_state_type;

  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_RATIO,
    TGT_SCALE,
    TGT_PREDIV
  } write_target_type;

  calc_state_type cur_ff;
  calc_state_type nxt_state;
  reg_write_type  port_wr;

  // ****************************************
  // functions
  // ****************************************
  // scale by a power of two; lost bits are the caller's concern
  function automatic logic [RATIO_WIDTH-1:0] apply_scale(
    input logic [RATIO_WIDTH-1:0] ratio,
    input logic [2:0]             sel
  );
    case (sel)
      3'h0: begin
        apply_scale = ratio;
      end
      3'h1: begin
        apply_scale = ratio << 1;
      end
      3'h2: begin
        apply_scale = ratio << 2;
      end
      3'h3: begin
        apply_scale = ratio << 3;
      end
      3'h4: begin
        apply_scale = ratio >> 1;
      end
      3'h5: begin
        apply_scale = ratio >> 2;
      end
      3'h6: begin
        apply_scale = ratio >> 3;
      end
      default: begin
        apply_scale = ratio >> 4;
      end
    endcase
  endfunction : apply_scale

  // ratio against the divided reference, so software sees only out/in
  function automatic logic [SYNTH_WIDTH-1:0] compensate(
    input logic [RATIO_WIDTH-1:0] ratio,
    input logic [1:0]             prediv
  );
    logic [SYNTH_WIDTH-1:0] wide;
    wide = {2'h0, ratio};
    case (prediv)
      PREDIV_DIV4: begin
        compensate = wide << 2;
      end
      PREDIV_DIV2: begin
        compensate = wide << 1;
      end
      PREDIV_DIV1: begin
        compensate = wide;
      end
      default: begin
        // undefined code taken as divide by one
        compensate = wide;
      end
    endcase
  endfunction : compensate

  // ****************************************
  // register decode
  // ****************************************
  // true when the address falls inside the four ratio bytes
  function automatic logic ratio_addr_hit(
    input logic [7:0] addr
  );
    ratio_addr_hit = (addr >= RATIO_OFFSET) && (addr <= RATIO_LAST_OFF);
  endfunction : ratio_addr_hit

  // byte lane of a ratio write, counted from the most significant byte
  function automatic logic [1:0] ratio_lane(
    input logic [7:0] addr
  );
    logic [7:0] rel;
    rel        = addr - RATIO_OFFSET;
    ratio_lane = rel[1:0];
  endfunction : ratio_lane

  // lowest address holds the most significant byte (integer part first)
  function automatic logic [RATIO_WIDTH-1:0] merge_ratio_byte(
    input logic [RATIO_WIDTH-1:0] ratio,
    input logic [1:0]             lane,
    input logic [7:0]             data
  );
    merge_ratio_byte = ratio;
    case (lane)
      2'h0: begin
        merge_ratio_byte[31:24] = data;
      end
      2'h1: begin
        merge_ratio_byte[23:16] = data;
      end
      2'h2: begin
        merge_ratio_byte[15:8] = data;
      end
      default: begin
        merge_ratio_byte[7:0] = data;
      end
    endcase
  endfunction : merge_ratio_byte

  // modifier select field of a written data byte
  function automatic logic [2:0] scale_field(
    input logic [7:0] data
  );
    scale_field = data[SCALE_SEL_LSB +: 3];
  endfunction : scale_field

  // predivider select field of a written data byte
  function automatic logic [1:0] prediv_field(
    input logic [7:0] data
  );
    prediv_field = data[PREDIV_LSB +: 2];
  endfunction : prediv_field

  // which register a written address belongs to
  function automatic write_target_type write_target(
    input logic [7:0] addr
  );
    if (ratio_addr_hit(addr)) begin
      write_target = TGT_RATIO;
    end else if (addr == SCALE_SEL_OFFSET) begin
      write_target = TGT_SCALE;
    end else if (addr == PREDIV_OFFSET) begin
      write_target = TGT_PREDIV;
    end else begin
      write_target = TGT_NONE;
    end
  endfunction : write_target

  // ****************************************
  // control port
  // ****************************************
  serial_write_port port_inst (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .cs_n_in    (cs_n_in),
    .cclk_in    (cclk_in),
    .cdin_in    (cdin_in),
    .wr_out     (port_wr)
  );

  // ****************************************
  // register writes and ratio path
  // ****************************************
  always_comb begin
    logic [1:0] lane;
    lane      = ratio_lane(port_wr.addr);
    nxt_state = cur_ff;
    // one byte lands per write pulse; unmapped addresses leave every field alone
    if (port_wr.valid) begin
      case (write_target(port_wr.addr))
        TGT_RATIO: begin
          nxt_state.user_ratio = merge_ratio_byte(cur_ff.user_ratio, lane, port_wr.data);
        end
        TGT_SCALE: begin
          nxt_state.scale_sel = scale_field(port_wr.data);
        end
        TGT_PREDIV: begin
          nxt_state.prediv_sel = prediv_field(port_wr.data);
        end
        default: begin
          nxt_state = cur_ff;
        end
      endcase
    end
    // stored ratio untouched; only the derived copies are scaled
    nxt_state.effective_ratio = apply_scale(cur_ff.user_ratio, cur_ff.scale_sel);
    nxt_state.synth_ratio     = compensate(cur_ff.effective_ratio, cur_ff.prediv_sel);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur_ff.user_ratio      <= RATIO_RESET;
      cur_ff.scale_sel       <= SCALE_SEL_RESET;
      cur_ff.prediv_sel      <= PREDIV_RESET;
      cur_ff.effective_ratio <= RATIO_RESET;
      cur_ff.synth_ratio     <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign user_ratio_out            = cur_ff.user_ratio;
  assign ratio_scale_select_out    = cur_ff.scale_sel;
  assign ref_predivider_select_out = cur_ff.prediv_sel;
  assign effective_ratio_out       = cur_ff.effective_ratio;
  assign synth_ratio_out           = cur_ff.synth_ratio;

endmodule : synth_ratio_calculator

// ### test/ratio_chk.sv
// port assertions for the ratio calculator
`timescale 1ns/1ns
module ratio_chk
  import ratio_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   sys_rst_in,
  input wire logic                   cs_n_in,
  input wire logic [RATIO_WIDTH-1:0] user_ratio_out,
  input wire logic [2:0]             ratio_scale_select_out,
  input wire logic [1:0]             ref_predivider_select_out,
  input wire logic [RATIO_WIDTH-1:0] effective_ratio_out,
  input wire logic [SYNTH_WIDTH-1:0] synth_ratio_out
);
  // ****************************************
  // idle count of the control port
  // ****************************************
  logic [2:0] idle_ff;
  logic [2:0] nxt_idle;
  function automatic logic [31:0] scaled(input logic [31:0] r, input logic [2:0] s);
    return s[2] ? r >> ({1'b0, s[1:0]} + 3'h1) : r << s[1:0];
  endfunction : scaled
  always_comb nxt_idle = !cs_n_in ? 3'h0 : (idle_ff == 3'h7 ? idle_ff : idle_ff + 3'h1);
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) idle_ff <= 3'h0;
    else idle_ff <= nxt_idle;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_EFF_SCALE: assert property (effective_ratio_out ==
    scaled($past(user_ratio_out), $past(ratio_scale_select_out))) else $error("eff bad");
  AST_EFF_UNITY: assert property ($past(ratio_scale_select_out) == 3'h0 |->
    effective_ratio_out == $past(user_ratio_out)) else $error("unity bad");
  AST_SYNTH_COMP: assert property (synth_ratio_out == ({2'h0, $past(effective_ratio_out)} <<
    ($past(ref_predivider_select_out) == 2'h0 ? 2 : $past(ref_predivider_select_out) == 2'h1)))
    else $error("synth bad");
  AST_MOD_NO_TOUCH: assert property ($changed(ratio_scale_select_out) |->
    $stable(user_ratio_out)) else $error("ratio touched");
  AST_RATIO_HOLD: assert property (idle_ff >= 3'h3 |-> $stable(user_ratio_out))
    else $error("ratio moved");
  AST_SEL_HOLD: assert property (idle_ff >= 3'h3 |-> $stable(ratio_scale_select_out))
    else $error("select moved");
  AST_PREDIV_HOLD: assert property (idle_ff >= 3'h3 |-> $stable(ref_predivider_select_out))
    else $error("predivider moved");
  AST_SYNTH_HOLD: assert property (idle_ff == 3'h5 |-> $stable(synth_ratio_out) [*3])
    else $error("synth moved");
endmodule : ratio_chk
bind synth_ratio_calculator ratio_chk chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .cs_n_in(cs_n_in), .user_ratio_out(user_ratio_out), .synth_ratio_out(synth_ratio_out),
  .ratio_scale_select_out(ratio_scale_select_out), .effective_ratio_out(effective_ratio_out),
  .ref_predivider_select_out(ref_predivider_select_out));

// ### test/testbench.sv
// self-checking bench for the ratio calculator
`timescale 1ns/1ns
module testbench;
  import ratio_pkg::*;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, cs_n_in = 1'b1, cclk_in = 1'b0, cdin_in = 1'b0;
  logic [31:0] user, eff, r;
  logic [2:0]  sel;
  logic [1:0]  pdv;
  logic [33:0] syn;
  int          fail_count = 0, check_count = 0;
  always #4 clk_in = ~clk_in;
  synth_ratio_calculator dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in),
    .cclk_in(cclk_in), .cdin_in(cdin_in), .user_ratio_out(user), .ratio_scale_select_out(sel),
    .ref_predivider_select_out(pdv), .effective_ratio_out(eff), .synth_ratio_out(syn));
  // ****************************************
  // access tasks
  // ****************************************
  task automatic frame(input logic [47:0] bits, input int nbits);
    cs_n_in = 1'b0;
    for (int i = 47; i > 47 - nbits; i--) begin
      cdin_in = bits[i];
      repeat (2) @(posedge clk_in);
      #1 cclk_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 cclk_in = 1'b0;
    end
    cs_n_in = 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : frame
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    print_verdict();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    chk("sel", 34'h0, {31'h0, sel});
    chk("ratio", 34'h0, {2'h0, user});
    chk("synth", 34'h0, syn);
    r = 32'h0123_4560;
    frame({CHIP_ADDR_VALUE, RATIO_OFFSET, r}, 48);
    chk("ratio", {2'h0, r}, {2'h0, user});
    for (int s = 0; s < 8; s++) begin
      frame({CHIP_ADDR_VALUE, SCALE_SEL_OFFSET, 5'h0, 3'(s), 24'h0}, 24);
      chk("sel", 34'(s), {31'h0, sel});
      chk("ratio", {2'h0, r}, {2'h0, user});
      chk("eff", {2'h0, s[2] ? r >> (s[1:0] + 1) : r << s[1:0]}, {2'h0, eff});
    end
    frame({CHIP_ADDR_VALUE, SCALE_SEL_OFFSET, 8'h00, 24'h0}, 24);
    chk("eff", {2'h0, r}, {2'h0, eff});
    for (int p = 0; p < 4; p++) begin
      frame({CHIP_ADDR_VALUE, PREDIV_OFFSET, 6'h0, 2'(p), 24'h0}, 24);
      chk("prediv", 34'(p), {32'h0, pdv});
      chk("synth", {2'h0, r} << (p == 0 ? 2 : p == 1 ? 1 : 0), syn);
    end
    frame({8'h9f, RATIO_OFFSET, 32'hffff_ffff}, 48);
    chk("ratio", {2'h0, r}, {2'h0, user});
    frame({CHIP_ADDR_VALUE, 8'h10, 8'hff, 24'h0}, 24);
    chk("sel", 34'h0, {31'h0, sel});
    frame({CHIP_ADDR_VALUE, RATIO_OFFSET, 32'hffff_ffff}, 20);
    chk("ratio", {2'h0, r}, {2'h0, user});
    frame({CHIP_ADDR_VALUE, RATIO_LAST_OFF, 8'hab, 24'h0}, 24);
    chk("ratio", {2'h0, r[31:8], 8'hab}, {2'h0, user});
    print_verdict();
  end
endmodule : testbench
